// ### rtl/hmp_defines.svh
// Constants of the host mailbox port: addresses, field positions, timing counts
`ifndef HMP_DEFINES_SVH
`define HMP_DEFINES_SVH

// Core-side register addresses
`define HMP_A_STAT_LO  4'h6
`define HMP_A_STAT_HI  4'h7
`define HMP_A_MMASK    4'h8
`define HMP_A_CMASK    4'h9
`define HMP_A_ISTAT    4'ha

// Host-side address of the upper status register
`define HMP_HA_STAT_HI 3'h7

// Field positions
`define HMP_RD_FLD     8
`define HMP_SR_BIT     0
`define HMP_BOOT_BIT   1
`define HMP_CM_RD_BIT  0
`define HMP_CM_WR_BIT  1

// Reset value of the synchroniser: strobes idle, select high, latch enable low
`define HMP_PIN_IDLE   5'h0f

// Host timing, in clock cycles
`define HMP_STROBE_CYC 6
`define HMP_ALE_HOLD   2

`endif

// ### rtl/hmp_pkg.sv
// Types shared by both ends of the host mailbox port
package hmp_pkg;

  typedef logic [15:0] hmp_word_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_ALE   = 3'b001,
    HS_AHOLD = 3'b010,
    HS_SETUP = 3'b011,
    HS_STRB  = 3'b100,
    HS_RECOV = 3'b101,
    HS_DONE  = 3'b110
  } hmp_hstate_t;

endpackage

// ### rtl/hmp_if.sv
// Pin-level link between the outside host and the mailbox port
`timescale 1ns/1ps
interface hmp_if;
  logic        width_sel;
  logic        style_sel;
  logic        mux_sel;
  logic        rd_n;
  logic        wr_n;
  logic        ds_n;
  logic        rw;
  logic        ale;
  logic [2:0]  addr;
  logic [15:0] h_out;
  logic        h_oe_n;
  logic [15:0] d_out;
  logic        d_oe_n;
  logic [15:0] hd;

  // Undriven bus floats high through the pull-ups
  assign hd = !h_oe_n ? h_out : (!d_oe_n ? d_out : 16'hffff);

  modport host (
    output width_sel, style_sel, mux_sel, rd_n, wr_n, ds_n, rw, ale, addr,
    output h_out, h_oe_n,
    input  d_out, d_oe_n, hd
  );

  modport dev (
    input  width_sel, style_sel, mux_sel, rd_n, wr_n, ds_n, rw, ale, addr,
    input  h_out, h_oe_n, hd,
    output d_out, d_oe_n
  );
endinterface

// ### rtl/hmp_host.sv
// Host end: drives mailbox port pins from a simple command port
`timescale 1ns/1ps
`include "hmp_defines.svh"
module hmp_host
  import hmp_pkg::*;
#(
  parameter int STROBE_CYC = `HMP_STROBE_CYC,
  parameter int ALE_HOLD   = `HMP_ALE_HOLD
)(
  input  wire logic       clk,
  input  wire logic       rst,
  hmp_if.host             bus,
  input  wire logic       width_cfg,
  input  wire logic       style_cfg,
  input  wire logic       mux_cfg,
  input  wire logic [2:0] cmd_addr,
  input  wire hmp_word_t  cmd_wdata,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  output logic            busy_q,
  output hmp_word_t       rdata_q,
  output logic            rvalid_q
);

  hmp_hstate_t st_q;
  logic [7:0]  cnt_q;
  logic        byte_q;
  logic        op_wr_q;
  logic [2:0]  a_q;
  hmp_word_t   w_q;
  hmp_word_t   lane;

  // Strap levels are held steady; the device follows them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.width_sel <= 1'b1;
      bus.style_sel <= 1'b0;
      bus.mux_sel   <= 1'b0;
    end
    else
    begin
      bus.width_sel <= width_cfg; // [R1]
      bus.style_sel <= style_cfg; // [R2]
      bus.mux_sel   <= mux_cfg;   // [R3]
    end
  end

  // In byte mode the low byte goes first
  assign lane = bus.width_sel ? w_q :
                (byte_q ? {8'h00, w_q[15:8]} : {8'h00, w_q[7:0]}); // [R1]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q       <= HS_IDLE;
      cnt_q      <= 8'h00;
      byte_q     <= 1'b0;
      op_wr_q    <= 1'b0;
      a_q        <= 3'h0;
      w_q        <= 16'h0000;
      busy_q     <= 1'b0;
      rdata_q    <= 16'h0000;
      rvalid_q   <= 1'b0;
      bus.rd_n   <= 1'b1;
      bus.wr_n   <= 1'b1;
      bus.ds_n   <= 1'b1;
      bus.rw     <= 1'b1;
      bus.ale    <= 1'b0;
      bus.addr   <= 3'h0;
      bus.h_out  <= 16'h0000;
      bus.h_oe_n <= 1'b1;
    end
    else
    begin
      rvalid_q <= 1'b0;
      unique case (st_q)
        HS_IDLE:
        begin
          if (cmd_wr || cmd_rd)
          begin
            busy_q  <= 1'b1;
            op_wr_q <= cmd_wr;
            a_q     <= cmd_addr;
            w_q     <= cmd_wdata;
            byte_q  <= 1'b0;
            cnt_q   <= 8'h00;
            if (bus.mux_sel)
            begin
              // Address phase on the shared bus
              bus.ale    <= 1'b1; // [R3]
              bus.h_out  <= {13'h0000, cmd_addr};
              bus.h_oe_n <= 1'b0;
              st_q       <= HS_ALE;
            end
            else
            begin
              st_q <= HS_SETUP;
            end
          end
        end
        HS_ALE:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(STROBE_CYC - 1))
          begin
            bus.ale <= 1'b0;
            cnt_q   <= 8'h00;
            st_q    <= HS_AHOLD;
          end
        end
        HS_AHOLD:
        begin
          // Address stays on the bus until the device has seen the latch fall
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(ALE_HOLD - 1))
          begin
            cnt_q <= 8'h00;
            st_q  <= HS_SETUP;
          end
        end
        HS_SETUP:
        begin
          bus.addr   <= a_q;
          bus.h_out  <= lane;
          bus.h_oe_n <= !op_wr_q;
          if (bus.style_sel)
          begin
            bus.rw   <= !op_wr_q; // [R2]
            bus.ds_n <= 1'b0;
          end
          else if (op_wr_q)
          begin
            bus.wr_n <= 1'b0;
          end
          else
          begin
            bus.rd_n <= 1'b0;
          end
          cnt_q <= 8'h00;
          st_q  <= HS_STRB;
        end
        HS_STRB:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(STROBE_CYC - 1))
          begin
            bus.rd_n <= 1'b1;
            bus.wr_n <= 1'b1;
            bus.ds_n <= 1'b1;
            cnt_q    <= 8'h00;
            st_q     <= HS_RECOV;
            if (!op_wr_q)
            begin
              if (bus.width_sel)
                rdata_q <= bus.hd;
              else if (byte_q)
                rdata_q[15:8] <= bus.hd[7:0];
              else
                rdata_q[7:0] <= bus.hd[7:0];
            end
          end
        end
        HS_RECOV:
        begin
          // Write data held past the strobe so the device catches it
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(STROBE_CYC - 1))
          begin
            bus.h_oe_n <= 1'b1;
            cnt_q      <= 8'h00;
            if (!bus.width_sel && !byte_q)
            begin
              byte_q <= 1'b1; // [R1]
              st_q   <= HS_SETUP;
            end
            else
            begin
              st_q <= HS_DONE;
            end
          end
        end
        HS_DONE:
        begin
          busy_q   <= 1'b0;
          rvalid_q <= !op_wr_q;
          st_q     <= HS_IDLE;
        end
        default:
        begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

endmodule

// ### rtl/hmp_device.sv
// Device end: mailbox registers, status, interrupts and host boot loading
// Functional notes
// [R1] Width strap picks 8- or 16-bit host transfers
// [R2] Style strap picks separate or shared strobes
// [R3] Mux strap picks split or multiplexed address/data
// [R4] Six data, two status, one mask register; the code has two mask registers, mmask_q and cmask_q
// [R5] Core reaches data registers in its space
// [R6] Both sides read both status registers
// [R7] Upper status holds soft reset, both set
// [R8] Host write raises core write request; the code raises none while boot_mode_q is set
// [R9] Completed host read raises core read request
// [R10] Written and read flags kept per register
// [R11] Mask bits per register, read and write
// [R12] Core mask: global read and write enables
// [R13] Interrupt needs per-register and global enable
// [R14] Host accesses need no core-clock handshake
// [R15] Interrupt and polling both supported
// [R16] Host boot moves words into program memory
// [R17] Boot strap chooses host or external boot
// [R18] Host strobes synchronised before any effect
// [R19] Core read clears written, write clears read
`timescale 1ns/1ps
`include "hmp_defines.svh"
module hmp_device
  import hmp_pkg::*;
#(
  parameter int NREG = 6,
  parameter int PMW  = 14
)(
  input  wire logic           clk,
  input  wire logic           rst,
  hmp_if.dev                  bus,
  input  wire logic           boot_sel,
  input  wire logic [3:0]     core_addr,
  input  wire hmp_word_t      core_wdata,
  input  wire logic           core_wr,
  input  wire logic           core_rd,
  output hmp_word_t           core_rdata_q,
  output logic                irq_q,
  output logic                soft_reset_q,
  output logic                boot_mode_q,
  output logic                pm_we_q,
  output logic [PMW-1:0]      pm_addr_q,
  output hmp_word_t           pm_data_q
);
  hmp_word_t       data_q [NREG];
  logic [4:0]      s1_q, s2_q, s3_q;
  logic [2:0]      alat_q, ha;
  logic            byte_q, init_q;
  logic [NREG-1:0] wrf_q, rdf_q, c_rd_hit, c_wr_hit;
  hmp_word_t       istat_q, mmask_q, h_word, stat_lo, stat_hi, h_rsel, ev, gate;
  logic [1:0]      cmask_q;
  logic            rd_now, rd_was, wr_now, wr_was, rd_end, wr_end;
  logic            hit, word_done, h_wr_word, h_rd_word;
  // Strobe decode for either strap setting, bits {ale,rw,ds_n,wr_n,rd_n}
  function automatic logic rd_act(input logic [4:0] s, input logic style);
    rd_act = style ? (!s[2] && s[3]) : !s[0];
  endfunction
  function automatic logic wr_act(input logic [4:0] s, input logic style);
    wr_act = style ? (!s[2] && !s[3]) : !s[1];
  endfunction
  // Host pins are unrelated to clk; the second and third stages are decoded
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= `HMP_PIN_IDLE;
      s2_q <= `HMP_PIN_IDLE;
      s3_q <= `HMP_PIN_IDLE;
    end
    else
    begin
      s1_q <= {bus.ale, bus.rw, bus.ds_n, bus.wr_n, bus.rd_n}; // [R18] [R14]
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rd_now = rd_act(s2_q, bus.style_sel); // [R2]
  assign rd_was = rd_act(s3_q, bus.style_sel);
  assign wr_now = wr_act(s2_q, bus.style_sel);
  assign wr_was = wr_act(s3_q, bus.style_sel);
  assign rd_end = rd_was && !rd_now;
  assign wr_end = wr_was && !wr_now;
  // Multiplexed bus: address latched while the latch enable is seen high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      alat_q <= 3'h0;
    else if (s2_q[4])
      alat_q <= bus.hd[2:0]; // [R3]
  end
  assign ha        = bus.mux_sel ? alat_q : bus.addr; // [R3]
  assign hit       = (32'(ha) < NREG);
  assign word_done = bus.width_sel || byte_q; // [R1]
  assign h_wr_word = wr_end && word_done && hit;
  assign h_rd_word = rd_end && word_done && hit;
  assign h_word    = bus.width_sel ? bus.hd : {bus.hd[7:0], data_q[ha][7:0]};
  // Byte pointer: low byte first, high byte completes the word
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      byte_q <= 1'b0;
    else if (bus.width_sel)
      byte_q <= 1'b0;
    else if (rd_end || wr_end)
      byte_q <= !byte_q; // [R1]
  end
  // Boot source caught once, on the first edge after reset release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      init_q      <= 1'b0;
      boot_mode_q <= 1'b0;
    end
    else if (!init_q)
    begin
      init_q      <= 1'b1;
      boot_mode_q <= boot_sel; // [R17]
    end
    else if (core_wr && core_addr == `HMP_A_STAT_HI)
      boot_mode_q <= boot_mode_q && core_wdata[`HMP_BOOT_BIT];
  end
  // Mailbox data: host write wins a same-cycle core write to one register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      for (int i = 0; i < NREG; i++)
        data_q[i] <= 16'h0000;
    else
    begin
      if (core_wr && 32'(core_addr) < NREG)
        data_q[core_addr[2:0]] <= core_wdata; // [R5]
      if (wr_end && hit)
      begin
        if (bus.width_sel)
          data_q[ha] <= bus.hd;
        else if (byte_q)
          data_q[ha][15:8] <= bus.hd[7:0];
        else
          data_q[ha][7:0] <= bus.hd[7:0];
      end
    end
  end
  // Per-register flags; boot words leave the written flags alone
  generate
    for (genvar g = 0; g < NREG; g++)
    begin : g_flag
      assign c_rd_hit[g] = core_rd && core_addr == 4'(g);
      assign c_wr_hit[g] = core_wr && core_addr == 4'(g);
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          wrf_q[g] <= 1'b0;
          rdf_q[g] <= 1'b0;
        end
        else
        begin
          // Set wins over a clear in the same cycle
          wrf_q[g] <= (wrf_q[g] && !c_rd_hit[g]) ||
                      (h_wr_word && ha == 3'(g) && !boot_mode_q); // [R10] [R19]
          rdf_q[g] <= (rdf_q[g] && !c_wr_hit[g]) ||
                      (h_rd_word && ha == 3'(g)); // [R10] [R19]
        end
      end
    end
  endgenerate
  // Soft reset: host write wins a same-cycle core write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      soft_reset_q <= 1'b0;
    else if (wr_end && !byte_q && ha == `HMP_HA_STAT_HI)
      soft_reset_q <= bus.hd[`HMP_SR_BIT]; // [R7]
    else if (core_wr && core_addr == `HMP_A_STAT_HI)
      soft_reset_q <= core_wdata[`HMP_SR_BIT]; // [R7]
  end
  assign stat_lo = (16'(rdf_q) << `HMP_RD_FLD) | 16'(wrf_q); // [R6]
  assign stat_hi = 16'({boot_mode_q, soft_reset_q}); // [R6]
  // Host read path: data or status, byte lane chosen by the pointer
  always_comb
  begin
    h_rsel = 16'h0000;
    if (hit)
      h_rsel = data_q[ha];
    else if (ha == 3'(`HMP_A_STAT_LO))
      h_rsel = stat_lo;
    else
      h_rsel = stat_hi;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.d_out  <= 16'h0000;
      bus.d_oe_n <= 1'b1;
    end
    else
    begin
      bus.d_oe_n <= !rd_now; // [R18]
      bus.d_out  <= bus.width_sel ? h_rsel :
                    (byte_q ? {8'h00, h_rsel[15:8]} : {8'h00, h_rsel[7:0]});
    end
  end
  // Interrupts: sticky events, per-register and global masks
  assign ev   = (16'(h_rd_word ? (NREG'(1) << ha) : '0) << `HMP_RD_FLD) |
                16'((h_wr_word && !boot_mode_q) ? (NREG'(1) << ha) : '0); // [R8] [R9]
  assign gate = {{8{cmask_q[`HMP_CM_RD_BIT]}}, {8{cmask_q[`HMP_CM_WR_BIT]}}}; // [R12]
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      istat_q <= 16'h0000;
      mmask_q <= 16'h0000;
      cmask_q <= 2'h0;
      irq_q   <= 1'b0;
    end
    else
    begin
      if (core_wr && core_addr == `HMP_A_ISTAT)
        istat_q <= (istat_q & ~core_wdata) | ev; // [R15]
      else
        istat_q <= istat_q | ev;
      if (core_wr && core_addr == `HMP_A_MMASK)
        mmask_q <= core_wdata; // [R11]
      if (core_wr && core_addr == `HMP_A_CMASK)
        cmask_q <= core_wdata[1:0]; // [R12]
      irq_q <= |(istat_q & mmask_q & gate); // [R13]
    end
  end
  // Boot loading: each completed host word goes to program memory
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pm_we_q   <= 1'b0;
      pm_addr_q <= '0;
      pm_data_q <= 16'h0000;
    end
    else
    begin
      pm_we_q <= h_wr_word && boot_mode_q; // [R16]
      if (pm_we_q)
        pm_addr_q <= pm_addr_q + PMW'(1);
      if (h_wr_word && boot_mode_q)
        pm_data_q <= h_word; // [R16]
    end
  end
  // Core register reads, answered one cycle later
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      core_rdata_q <= 16'h0000;
    else if (core_rd)
    begin
      if (32'(core_addr) < NREG)
        core_rdata_q <= data_q[core_addr[2:0]]; // [R5] [R4]
      else
        unique case (core_addr)
          `HMP_A_STAT_LO: core_rdata_q <= stat_lo; // [R6]
          `HMP_A_STAT_HI: core_rdata_q <= stat_hi;
          `HMP_A_MMASK:   core_rdata_q <= mmask_q;
          `HMP_A_CMASK:   core_rdata_q <= 16'(cmask_q);
          `HMP_A_ISTAT:   core_rdata_q <= istat_q;
          default:        core_rdata_q <= 16'h0000;
        endcase
    end
  end
endmodule

// ### bench/hmp_port_sva.sv
// Pin protocol checks between the host end and the mailbox port
`timescale 1ns/1ps
module hmp_port_sva (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        style_sel,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        ds_n,
  input wire logic        rw,
  input wire logic        ale,
  input wire logic [15:0] h_out,
  input wire logic        h_oe_n,
  input wire logic        d_oe_n,
  input wire logic [15:0] hd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_one_drv; !(!h_oe_n && !d_oe_n); endproperty
  a_one_drv: assert property (p_one_drv) else $error("both ends drive hd");
  property p_sep_strb; !style_sel |-> (rd_n || wr_n); endproperty
  a_sep_strb: assert property (p_sep_strb) else $error("read and write strobe together");
  property p_strb_len; $fell(wr_n) |-> !wr_n [*4]; endproperty
  a_strb_len: assert property (p_strb_len) else $error("write strobe too short");
  property p_recov; $rose(rd_n) |-> rd_n [*3]; endproperty
  a_recov: assert property (p_recov) else $error("read recovery too short");
  property p_wdata_hold; $rose(wr_n) |-> (!h_oe_n && $stable(h_out)) [*3]; endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("write data not held");
  property p_ale_len; $rose(ale) |-> ale [*3]; endproperty
  a_ale_len: assert property (p_ale_len) else $error("latch enable too short");
  property p_addr_hold; $fell(ale) |-> $stable(hd) [*2]; endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address not held");
  property p_rd_drive; $fell(d_oe_n) |-> (style_sel ? (!ds_n && rw) : !rd_n); endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("device drives outside read");
  property p_rd_turn; !style_sel && $fell(rd_n) |-> ##[2:4] !d_oe_n; endproperty
  a_rd_turn: assert property (p_rd_turn) else $error("device late to drive");
  property p_rd_rel; $rose(rd_n) |-> ##[2:4] d_oe_n; endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("device late to release");
endmodule

// ### bench/host_mailbox_port_bench.sv
// Bench: host end and device end joined, driven from their user ports
`timescale 1ns/1ps
`include "hmp_defines.svh"
module host_mailbox_port_bench;
  import hmp_pkg::*;
  logic        clk, rst, width_cfg, style_cfg, mux_cfg, cmd_wr, cmd_rd;
  logic        busy_q, rvalid_q, boot_sel, core_wr, core_rd;
  logic        irq_q, soft_reset_q, boot_mode_q, pm_we_q;
  logic [2:0]  cmd_addr;
  logic [3:0]  core_addr;
  logic [13:0] pm_addr_q;
  hmp_word_t   cmd_wdata, rdata_q, core_wdata, core_rdata_q, pm_data_q;
  hmp_word_t   pm_q[$];
  logic [13:0] pa_q[$];
  int          fails, comparisons, i;
  localparam logic [2:0] MODES [4] = '{3'b110, 3'b101, 3'b000, 3'b011};

  hmp_if u_hmp_if ();
  hmp_host u_hmp_host (.clk(clk), .rst(rst), .bus(u_hmp_if), .width_cfg(width_cfg),
    .style_cfg(style_cfg), .mux_cfg(mux_cfg), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .busy_q(busy_q), .rdata_q(rdata_q), .rvalid_q(rvalid_q));
  hmp_device u_hmp_device (.clk(clk), .rst(rst), .bus(u_hmp_if), .boot_sel(boot_sel),
    .core_addr(core_addr), .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
    .core_rdata_q(core_rdata_q), .irq_q(irq_q), .soft_reset_q(soft_reset_q),
    .boot_mode_q(boot_mode_q), .pm_we_q(pm_we_q), .pm_addr_q(pm_addr_q), .pm_data_q(pm_data_q));
  hmp_port_sva u_hmp_port_sva (.clk(clk), .rst(rst), .style_sel(u_hmp_if.style_sel),
    .rd_n(u_hmp_if.rd_n), .wr_n(u_hmp_if.wr_n), .ds_n(u_hmp_if.ds_n), .rw(u_hmp_if.rw),
    .ale(u_hmp_if.ale), .h_out(u_hmp_if.h_out), .h_oe_n(u_hmp_if.h_oe_n),
    .d_oe_n(u_hmp_if.d_oe_n), .hd(u_hmp_if.hd));

  always #25 clk = ~clk;

  // Mid-cycle sample, while the word and its address both stand
  always @(negedge clk)
    if (pm_we_q === 1'b1)
    begin
      pm_q.push_back(pm_data_q);
      pa_q.push_back(pm_addr_q);
    end

  task automatic end_sim;
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string s, input hmp_word_t seen, input hmp_word_t exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic do_reset(input logic b);
    rst <= 1'b1;
    boot_sel <= b;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic core_op(input logic w, input logic [3:0] a, input hmp_word_t d,
                         output hmp_word_t r);
    @(posedge clk);
    core_wr <= w;
    core_rd <= !w;
    core_addr <= a;
    core_wdata <= d;
    @(posedge clk);
    core_wr <= 1'b0;
    core_rd <= 1'b0;
    #1;
    r = core_rdata_q;
  endtask

  // Returns only once the device has had time to see the strobe end
  task automatic host_op(input logic w, input logic [2:0] a, input hmp_word_t d,
                         output hmp_word_t r);
    int n;
    @(posedge clk);
    cmd_wr <= w;
    cmd_rd <= !w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    #1;
    n = 0;
    while (busy_q !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400)
    begin
      fails++;
      end_sim;
    end
    check("rvalid", rvalid_q, {15'h0000, !w});
    r = rdata_q;
    repeat (2) @(posedge clk);
  endtask

  task automatic cw(input logic [3:0] a, input hmp_word_t d);
    hmp_word_t r;
    core_op(1'b1, a, d, r);
  endtask
  task automatic cr(input logic [3:0] a, input hmp_word_t e, input string s);
    hmp_word_t r;
    core_op(1'b0, a, 16'h0000, r);
    check(s, r, e);
  endtask
  task automatic hw(input logic [2:0] a, input hmp_word_t d);
    hmp_word_t r;
    host_op(1'b1, a, d, r);
  endtask
  task automatic hr(input logic [2:0] a, input hmp_word_t e, input string s);
    hmp_word_t r;
    host_op(1'b0, a, 16'h0000, r);
    check(s, r, e);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1;
    check("irq", irq_q, e);
  endtask

  initial
  begin
    clk = 0; rst = 1; boot_sel = 0; width_cfg = 1; style_cfg = 0; mux_cfg = 0;
    cmd_wr = 0; cmd_rd = 0; cmd_addr = 3'h0; cmd_wdata = 16'h0000;
    core_wr = 0; core_rd = 0; core_addr = 4'h0; core_wdata = 16'h0000;
    do_reset(1'b0);
    cr(`HMP_A_STAT_LO, 16'h0000, "stat_lo");
    cw(4'hb, 16'hffff);
    cr(4'hb, 16'h0000, "unmapped");
    cw(`HMP_A_MMASK, 16'h3f3f);
    cr(`HMP_A_MMASK, 16'h3f3f, "mmask");
    cw(`HMP_A_CMASK, 16'h0003);
    for (i = 0; i < 6; i++) hw(i[2:0], {12'ha50, i[3:0]});
    irq_is(1'b1);
    cr(`HMP_A_STAT_LO, 16'h003f, "stat_lo");
    cr(`HMP_A_ISTAT, 16'h003f, "istat");
    for (i = 0; i < 6; i++) cr(i[3:0], {12'ha50, i[3:0]}, "data");
    cr(`HMP_A_STAT_LO, 16'h0000, "stat_lo");
    cw(`HMP_A_ISTAT, 16'h003f);
    irq_is(1'b0);
    cw(4'h2, 16'h5a5a);
    hr(3'h2, 16'h5a5a, "host_rd");
    cr(`HMP_A_STAT_LO, 16'h0400, "stat_lo");
    irq_is(1'b1);
    cw(4'h2, 16'h1234);
    cr(`HMP_A_STAT_LO, 16'h0000, "stat_lo");
    cw(`HMP_A_ISTAT, 16'h0400);
    // Global write enable off: status still records, line stays low
    cw(`HMP_A_CMASK, 16'h0001);
    hw(3'h0, 16'h0f0f);
    cr(`HMP_A_ISTAT, 16'h0001, "istat");
    irq_is(1'b0);
    cw(`HMP_A_CMASK, 16'h0003);
    irq_is(1'b1);
    cw(`HMP_A_MMASK, 16'h3f3e);
    irq_is(1'b0);
    cw(`HMP_A_ISTAT, 16'hffff);
    cw(`HMP_A_MMASK, 16'h3f3f);
    hw(`HMP_HA_STAT_HI, 16'h0001);
    check("soft_reset", soft_reset_q, 1'b1);
    cr(`HMP_A_STAT_HI, 16'h0001, "stat_hi");
    hr(`HMP_HA_STAT_HI, 16'h0001, "host_hi");
    cw(`HMP_A_STAT_HI, 16'h0000);
    hr(`HMP_HA_STAT_HI, 16'h0000, "host_hi");
    check("soft_reset", soft_reset_q, 1'b0);
    cw(`HMP_A_STAT_HI, 16'h0001);
    check("soft_reset", soft_reset_q, 1'b1);
    cw(`HMP_A_STAT_HI, 16'h0000);
    // Host writes to the lower status register are ignored
    hw(3'h6, 16'hffff);
    hr(3'h6, 16'h0001, "host_lo");
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      {width_cfg, style_cfg, mux_cfg} <= MODES[i];
      repeat (2) @(posedge clk);
      hw(3'h3, {12'h3c5, i[3:0]});
      cr(4'h3, {12'h3c5, i[3:0]}, "mode_wr");
      cw(4'h4, {12'hc3a, i[3:0]});
      hr(3'h4, {12'hc3a, i[3:0]}, "mode_rd");
    end
    @(posedge clk);
    {width_cfg, style_cfg, mux_cfg} <= 3'b100;
    // Second reset mid-run, now booting from the host
    do_reset(1'b1);
    check("boot_mode", boot_mode_q, 1'b1);
    cr(`HMP_A_STAT_HI, 16'h0002, "stat_hi");
    hw(3'h0, 16'h1111);
    hw(3'h0, 16'h2222);
    check("pm_count", 16'(pm_q.size()), 16'h0002);
    check("pm_data0", pm_q[0], 16'h1111);
    check("pm_data1", pm_q[1], 16'h2222);
    check("pm_addr0", {2'b00, pa_q[0]}, 16'h0000);
    check("pm_addr1", {2'b00, pa_q[1]}, 16'h0001);
    cr(`HMP_A_STAT_LO, 16'h0000, "stat_lo");
    cw(`HMP_A_STAT_HI, 16'h0000);
    @(posedge clk);
    #1;
    check("boot_mode", boot_mode_q, 1'b0);
    end_sim;
  end
endmodule
